// ===== hw/ohd_pkg.sv
// Constants, opcode patterns, register map and carrier types of the decoder.
// Assumes the fetch stage and datapath share ref_clk with the decoder.
package ohd_pkg;

    // ********************************************************
    // Widths and register map
    // ********************************************************
    localparam int OHD_DATA_W = 32;
    localparam logic [3:0] OHD_OFS_CTRL = 4'h0;
    localparam logic [3:0] OHD_OFS_STATUS = 4'h4;
    localparam logic [3:0] OHD_OFS_LAST = 4'h8;
    localparam logic OHD_RST_ENABLE = 1'h1;
    localparam logic [15:0] OHD_RST_COUNT = 16'h0000;
    localparam logic [31:0] OHD_RST_WORD = 32'h0000_0000;
    localparam int OHD_CTRL_EN_BIT = 0;

    // ********************************************************
    // Field codes
    // ********************************************************
    localparam logic [1:0] OHD_SZ_B = 2'h0;
    localparam logic [1:0] OHD_SZ_W = 2'h1;
    localparam logic [1:0] OHD_SZ_L = 2'h2;
    localparam logic [1:0] OHD_SZ_BAD = 2'h3;
    localparam logic [1:0] OHD_SH_ARITH = 2'h0;
    localparam logic [1:0] OHD_SH_LOGIC = 2'h1;
    localparam logic [1:0] OHD_SH_ROTX = 2'h2;
    localparam logic [1:0] OHD_SH_ROT = 2'h3;
    localparam logic [2:0] OHD_MODE_DREG = 3'h0;
    localparam logic [2:0] OHD_MODE_AREG = 3'h1;
    localparam logic [2:0] OHD_ADD_TO_ADDRESS_REG_W = 3'h3;
    localparam logic [2:0] OHD_ADD_TO_ADDRESS_REG_L = 3'h7;
    localparam logic [4:0] OHD_BCD_PAT = 5'h10;
    localparam logic [5:0] OHD_XCH_DD = 6'h28;
    localparam logic [5:0] OHD_XCH_AA = 6'h29;
    localparam logic [5:0] OHD_XCH_DA = 6'h31;
    localparam logic [15:0] OHD_HALT_OP = 16'hF800;
    localparam logic [15:0] OHD_HALT_EXT = 16'h01C0;
    localparam logic [9:0] OHD_TBL_OP = 10'h3E0;
    localparam logic [1:0] OHD_TBL_REGFORM = 2'h0;
    localparam logic [1:0] OHD_TBL_MEMFORM = 2'h1;
    localparam logic [7:0] OHD_HALF = 8'h80;
    localparam int OHD_FRAC_W = 8;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [3:0] {
        OHD_OP_OTHER,
        OHD_OP_XOR_EA,
        OHD_OP_COMPARE_MEMORY_POSTINC,
        OHD_OP_AND,
        OHD_OP_MUL,
        OHD_OP_BCD_ADD,
        OHD_OP_SWAP,
        OHD_OP_ADD,
        OHD_OP_ADD_TO_ADDRESS_REG,
        OHD_OP_ADD_WITH_EXTEND,
        OHD_OP_SHIFT_REG,
        OHD_OP_SHIFT_MEM,
        OHD_OP_HALT,
        OHD_OP_TBL
    } ohd_op_e;

    typedef struct packed {
        logic illegal;
        ohd_op_e op;
        logic [1:0] size;
        logic isSigned;
        logic rounded;
        logic memToMem;
        logic predec;
        logic dstIsEa;
        logic [2:0] regX;
        logic [2:0] regY;
        logic [1:0] swapMode;
        logic cntIsReg;
        logic [2:0] cntField;
        logic dirLeft;
        logic [1:0] shType;
        logic tblRegPair;
    } ohd_ctrl_s;

endpackage : ohd_pkg

// ===== hw/ohd_interp.sv
// Table interpolation unit: entry + frac*(next-entry)/256 rounded, or raw as entry*256 + frac*(next-entry).
// Assumes the datapath presents both table entries with the start pulse.
`timescale 1ns/1ps
module ohd_interp
    import ohd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Request
    input wire logic start,
    input wire logic [1:0] size,
    input wire logic isSigned,
    input wire logic rounded,
    input wire logic [31:0] entry,
    input wire logic [31:0] nextEntry,
    input wire logic [31:0] indepVar,
    // Answer
    output logic done,
    output logic [31:0] result,
    output logic [7:0] entryOffset
);

    function automatic logic [32:0] ext33(input logic [31:0] v, input logic [1:0] sz,
                                          input logic sg);
        case (sz)
            OHD_SZ_B: ext33 = {{25{sg & v[7]}}, v[7:0]};
            OHD_SZ_W: ext33 = {{17{sg & v[15]}}, v[15:0]};
            default: ext33 = {sg & v[31], v};
        endcase
    endfunction : ext33

    logic [32:0] e;
    logic [32:0] n;
    logic signed [33:0] diff;
    logic signed [42:0] prod;
    logic signed [42:0] fixedVal;
    logic roundUp;
    logic [34:0] roundedVal;

    always_comb begin
        e = ext33(entry, size, isSigned);
        n = ext33(nextEntry, size, isSigned);
        diff = $signed({n[32], n}) - $signed({e[32], e});
        // Fraction is the low byte of the independent variable
        prod = diff * $signed({1'b0, indepVar[7:0]});
        fixedVal = $signed({{2{e[32]}}, e, 8'h00}) + prod;
        // Nearest, ties to even integer part
        roundUp = (fixedVal[7:0] > OHD_HALF) ||
                  ((fixedVal[7:0] == OHD_HALF) && fixedVal[8]);
        roundedVal = fixedVal[42:8] + {34'h0_0000_0000, roundUp};
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
            result <= OHD_RST_WORD;
            entryOffset <= 8'h00;
        end else begin
            done <= start;
            if (start) begin
                result <= rounded ? roundedVal[31:0] : fixedVal[31:0];
                entryOffset <= indepVar[15:8];
            end
        end
    end

    property p_zero_frac;
        @(posedge ref_clk) disable iff (!reset_n)
        (start && rounded && indepVar[7:0] == 8'h00) |=> (result == 32'(ext33(
            $past(entry), $past(size), $past(isSigned))));
    endproperty
    a_zero_frac: assert property (p_zero_frac) else $error("interp frac 0");

    property p_tie_even;
        @(posedge ref_clk) disable iff (!reset_n)
        (start && rounded && size == OHD_SZ_B && entry == 32'h0000_0000 &&
         nextEntry == 32'h0000_0001 && indepVar[7:0] == OHD_HALF) |=> (result == 32'h0000_0000);
    endproperty
    a_tie_even: assert property (p_tie_even) else $error("half not to even");

    property p_raw_scaled;
        @(posedge ref_clk) disable iff (!reset_n)
        (start && !rounded && size == OHD_SZ_B && !isSigned && indepVar[7:0] == 8'h00)
        |=> (result == {16'h0000, $past(entry[7:0]), 8'h00});
    endproperty
    a_raw_scaled: assert property (p_raw_scaled) else $error("raw not scaled");

endmodule : ohd_interp

// ===== hw/ohd_decoder.sv
// Upper opcode group decoder with table interpolation unit and Avalon-MM
// register slave. Assumes fetch and datapath run on ref_clk.
// Notes on behaviour
// - XOR opmodes 100/101/110 give XOR of data register into operand, written there.
// - Compare-memory size field 00 byte, 01 word, 10 long.
// - Word multiply type bit 0 unsigned, 1 signed.
// - Decimal add bit 0 register to register, 1 memory to memory.
// - Decimal add memory form uses address registers with predecrement.
// - Add-extended bit 0 data registers, 1 predecrement memory via address registers.
// - Add-address opmode 011 word source, 111 long source, sum to address register.
// - Shift with I/R 0 takes the count field as the count.
// - Shift with I/R 1 takes the count field as a data register number.
// - Shift direction bit 0 right, 1 left.
// - Shift type 00 arithmetic, 01 logical, 10 rotate extend, 11 rotate.
// - Interpolate type bit 0 signed, 1 unsigned.
// - Interpolate rounding bit 0 rounded, 1 raw.
// - Rounded signed interpolation delivers byte, word or long signed result.
// - Rounded unsigned interpolation delivers byte, word or long unsigned result.
// - Table data from memory table or a register pair.
// - Entry offset is bits 15..8 of the independent variable.
// - Fraction is bits 7..0 of the independent variable.
// - Result is entry plus fraction times difference over 256.
// - Rounded forms round to nearest, ties to even.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module ohd_decoder
    import ohd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fetch stage
    input wire logic insnValid,
    input wire logic [15:0] opword,
    input wire logic [15:0] extWord,
    // Decoded controls
    output logic ctrlValid,
    output ohd_ctrl_s ctrl,
    // Interpolation request
    input wire logic interpStart,
    input wire logic [31:0] interpEntry,
    input wire logic [31:0] interpNext,
    input wire logic [31:0] independentVar,
    // Interpolation answer
    output logic interpDone,
    output logic [31:0] interpResult,
    output logic [7:0] interpOffset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ********************************************************
    // State
    // ********************************************************
    ohd_ctrl_s next_ctrl;
    logic decodeEnable;
    logic [15:0] illegalCount;
    logic [31:0] lastWords;
    logic [1:0] tblSize;
    logic tblSigned;
    logic tblRounded;
    logic busCommit;
    logic [3:0] regAddr;

    // ********************************************************
    // Decode
    // ********************************************************
    always_comb begin
        next_ctrl = '0;
        next_ctrl.op = OHD_OP_OTHER;
        next_ctrl.regX = opword[11:9];
        next_ctrl.regY = opword[2:0];
        unique case (opword[15:12])
            4'hB: begin
                if (opword[8] && opword[5:3] == OHD_MODE_AREG) begin
                    next_ctrl.op = OHD_OP_COMPARE_MEMORY_POSTINC;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.memToMem = 1'b1;
                    next_ctrl.illegal = (opword[7:6] == OHD_SZ_BAD);
                end else if (opword[8] && opword[7:6] != OHD_SZ_BAD) begin
                    next_ctrl.op = OHD_OP_XOR_EA;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.dstIsEa = 1'b1;
                end
            end
            4'hC: begin
                if (opword[8:4] == OHD_BCD_PAT) begin
                    next_ctrl.op = OHD_OP_BCD_ADD;
                    next_ctrl.size = OHD_SZ_B;
                    next_ctrl.memToMem = opword[3];
                    next_ctrl.predec = opword[3];
                end else if (opword[8:3] == OHD_XCH_DD || opword[8:3] == OHD_XCH_AA
                             || opword[8:3] == OHD_XCH_DA) begin
                    next_ctrl.op = OHD_OP_SWAP;
                    next_ctrl.size = OHD_SZ_L;
                    next_ctrl.swapMode = {opword[7], opword[3]};
                end else if (opword[7:6] == OHD_SZ_BAD) begin
                    next_ctrl.op = OHD_OP_MUL;
                    next_ctrl.size = OHD_SZ_W;
                    next_ctrl.isSigned = opword[8];
                end else if (opword[8] && opword[5:4] == 2'h0) begin
                    next_ctrl.illegal = 1'b1;
                end else begin
                    next_ctrl.op = OHD_OP_AND;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.dstIsEa = opword[8];
                end
            end
            4'hD: begin
                if (opword[7:6] == OHD_SZ_BAD) begin
                    next_ctrl.op = OHD_OP_ADD_TO_ADDRESS_REG;
                    next_ctrl.size = (opword[8:6] == OHD_ADD_TO_ADDRESS_REG_L) ? OHD_SZ_L : OHD_SZ_W;
                end else if (opword[8] && opword[5:4] == 2'h0) begin
                    next_ctrl.op = OHD_OP_ADD_WITH_EXTEND;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.memToMem = opword[3];
                    next_ctrl.predec = opword[3];
                end else begin
                    next_ctrl.op = OHD_OP_ADD;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.dstIsEa = opword[8];
                end
            end
            4'hE: begin
                next_ctrl.dirLeft = opword[8];
                if (opword[7:6] == OHD_SZ_BAD) begin
                    next_ctrl.op = OHD_OP_SHIFT_MEM;
                    next_ctrl.size = OHD_SZ_W;
                    next_ctrl.shType = opword[10:9];
                    next_ctrl.illegal = opword[11];
                end else begin
                    next_ctrl.op = OHD_OP_SHIFT_REG;
                    next_ctrl.size = opword[7:6];
                    next_ctrl.shType = opword[4:3];
                    next_ctrl.cntIsReg = opword[5];
                    next_ctrl.cntField = opword[11:9];
                end
            end
            4'hF: begin
                if (opword == OHD_HALT_OP && extWord == OHD_HALT_EXT) begin
                    next_ctrl.op = OHD_OP_HALT;
                end else if (opword[15:6] == OHD_TBL_OP && !extWord[15]) begin
                    next_ctrl.op = OHD_OP_TBL;
                    next_ctrl.isSigned = !extWord[11];
                    next_ctrl.rounded = !extWord[10];
                    next_ctrl.size = extWord[7:6];
                    next_ctrl.regX = extWord[14:12];
                    if (opword[5:3] == OHD_MODE_DREG) begin
                        next_ctrl.tblRegPair = 1'b1;
                        next_ctrl.illegal = (extWord[9:8] != OHD_TBL_REGFORM) ||
                                            (extWord[5:3] != 3'h0);
                    end else begin
                        next_ctrl.illegal = (extWord[9:8] != OHD_TBL_MEMFORM) ||
                                            (extWord[5:0] != 6'h00);
                    end
                    if (extWord[7:6] == OHD_SZ_BAD) begin
                        next_ctrl.illegal = 1'b1;
                    end
                end else begin
                    next_ctrl.illegal = 1'b1;
                end
            end
            default: begin
                next_ctrl.op = OHD_OP_OTHER;
            end
        endcase
        // Illegal words carry no operation to the datapath
        if (next_ctrl.illegal) begin
            next_ctrl.op = OHD_OP_OTHER;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlValid <= 1'b0;
            ctrl <= '0;
        end else begin
            ctrlValid <= insnValid && decodeEnable;
            if (insnValid && decodeEnable) begin
                ctrl <= next_ctrl;
            end
        end
    end

    // ********************************************************
    // Table mode latched for the interpolation unit
    // ********************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tblSize <= OHD_SZ_B;
            tblSigned <= 1'b0;
            tblRounded <= 1'b0;
        end else if (insnValid && decodeEnable && next_ctrl.op == OHD_OP_TBL) begin
            tblSize <= next_ctrl.size;
            tblSigned <= next_ctrl.isSigned;
            tblRounded <= next_ctrl.rounded;
        end
    end

    ohd_interp u_interp (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(interpStart),
        .size(tblSize),
        .isSigned(tblSigned),
        .rounded(tblRounded),
        .entry(interpEntry),
        .nextEntry(interpNext),
        .indepVar(independentVar),
        .done(interpDone),
        .result(interpResult),
        .entryOffset(interpOffset)
    );

    // ********************************************************
    // Avalon-MM slave
    // ********************************************************
    assign busCommit = (avs_read || avs_write) && !avs_waitrequest;
    assign regAddr = {avs_address[3:2], 2'h0};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= OHD_RST_WORD;
        end else if (avs_read && avs_waitrequest) begin
            case (regAddr)
                OHD_OFS_CTRL: avs_readdata <= {31'h0000_0000, decodeEnable};
                OHD_OFS_STATUS: avs_readdata <= {16'h0000, illegalCount};
                OHD_OFS_LAST: avs_readdata <= lastWords;
                default: avs_readdata <= OHD_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            decodeEnable <= OHD_RST_ENABLE;
        end else if (busCommit && avs_write && regAddr == OHD_OFS_CTRL && avs_byteenable[0]) begin
            decodeEnable <= avs_writedata[OHD_CTRL_EN_BIT];
        end
    end

    // Count of illegal words; a write clears it, a new one in the same cycle wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            illegalCount <= OHD_RST_COUNT;
        end else if (insnValid && decodeEnable && next_ctrl.illegal) begin
            if (busCommit && avs_write && regAddr == OHD_OFS_STATUS) begin
                illegalCount <= 16'h0001;
            end else if (illegalCount != 16'hFFFF) begin
                illegalCount <= illegalCount + 16'h0001;
            end
        end else if (busCommit && avs_write && regAddr == OHD_OFS_STATUS) begin
            illegalCount <= OHD_RST_COUNT;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lastWords <= OHD_RST_WORD;
        end else if (insnValid && decodeEnable) begin
            lastWords <= {extWord, opword};
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_take(logic [3:0] grp);
        insnValid && decodeEnable && opword[15:12] == grp;
    endsequence

    property p_xor_dest;
        s_take(4'hB) ##0 (opword[8] && opword[5:3] != OHD_MODE_AREG && opword[7:6] != OHD_SZ_BAD)
        |=> ctrlValid && ctrl.op == OHD_OP_XOR_EA && ctrl.dstIsEa && ctrl.size == $past(opword[7:6]);
    endproperty
    a_xor_dest: assert property (p_xor_dest) else $error("xor not decoded");

    property p_compare_memory_postinc_size;
        s_take(4'hB) ##0 (opword[8] && opword[5:3] == OHD_MODE_AREG)
        |=> (ctrl.illegal == ($past(opword[7:6]) == OHD_SZ_BAD)) &&
            (ctrl.illegal || (ctrl.op == OHD_OP_COMPARE_MEMORY_POSTINC && ctrl.size == $past(opword[7:6])));
    endproperty
    a_compare_memory_postinc_size: assert property (p_compare_memory_postinc_size) else $error("compare_memory_postinc size wrong");

    property p_mul_sign;
        s_take(4'hC) ##0 (opword[7:6] == OHD_SZ_BAD)
        |=> ctrl.op == OHD_OP_MUL && ctrl.isSigned == $past(opword[8]);
    endproperty
    a_mul_sign: assert property (p_mul_sign) else $error("mul sign wrong");

    property p_bcd_predec;
        s_take(4'hC) ##0 (opword[8:4] == OHD_BCD_PAT)
        |=> ctrl.op == OHD_OP_BCD_ADD && ctrl.predec == $past(opword[3]) &&
            ctrl.memToMem == ctrl.predec;
    endproperty
    a_bcd_predec: assert property (p_bcd_predec) else $error("bcd operand mode");

    property p_add_to_address_reg_size;
        s_take(4'hD) ##0 (opword[8:6] == OHD_ADD_TO_ADDRESS_REG_W)
        |=> ctrl.op == OHD_OP_ADD_TO_ADDRESS_REG && ctrl.size == OHD_SZ_W;
    endproperty
    a_add_to_address_reg_size: assert property (p_add_to_address_reg_size) else $error("add_to_address_reg size wrong");

    property p_shift_count;
        s_take(4'hE) ##0 (opword[7:6] != OHD_SZ_BAD)
        |=> ctrl.op == OHD_OP_SHIFT_REG && ctrl.cntIsReg == $past(opword[5]) &&
            ctrl.cntField == $past(opword[11:9]) && ctrl.shType == $past(opword[4:3]) &&
            ctrl.dirLeft == $past(opword[8]);
    endproperty
    a_shift_count: assert property (p_shift_count) else $error("shift fields wrong");

    property p_tbl_mode;
        s_take(4'hF) ##0 (opword[15:6] == OHD_TBL_OP && !extWord[15] && extWord[7:6] != OHD_SZ_BAD
                         && opword[5:3] != OHD_MODE_DREG && extWord[9:8] == OHD_TBL_MEMFORM
                         && extWord[5:0] == 6'h00)
        |=> ctrl.op == OHD_OP_TBL && ctrl.isSigned != $past(extWord[11]) &&
            ctrl.rounded != $past(extWord[10]) && !ctrl.tblRegPair;
    endproperty
    a_tbl_mode: assert property (p_tbl_mode) else $error("table mode wrong");

    property p_illegal_count;
        (insnValid && decodeEnable && next_ctrl.illegal && illegalCount < 16'h00FF &&
         !(avs_write && !avs_waitrequest))
        |=> ctrl.illegal && ctrl.op == OHD_OP_OTHER && illegalCount == $past(illegalCount) + 16'h0001;
    endproperty
    a_illegal_count: assert property (p_illegal_count) else $error("illegal not flagged");

    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");

endmodule : ohd_decoder

// ===== sim/ohd_fetch_model.sv
// Fetch-stage model: hands the decoder one word pair per request.
// Assumes the bench raises go for one ref_clk cycle.
`timescale 1ns/1ps
module ohd_fetch_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bench side
    input wire logic go,
    input wire logic [31:0] word,
    // Decoder side
    output logic insnValid,
    output logic [15:0] opword,
    output logic [15:0] extWord
);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            insnValid <= 1'b0;
        end else begin
            insnValid <= go;
        end
    end
    // Idle words are inverted so stale values never pass as fresh
    always_ff @(posedge ref_clk) begin
        {extWord, opword} <= go ? word : ~{extWord, opword};
    end
endmodule : ohd_fetch_model

// ===== sim/opcode_decode_hi_lines_table_interp_test.sv
// Testbench: decode of the upper groups, interpolation and register bus.
// Assumes ohd_pkg and the decoder are compiled first.
`timescale 1ns/1ps
module opcode_decode_hi_lines_table_interp_test
    import ohd_pkg::*;
;
    logic ref_clk = 0, reset_n = 0, go = 0, interpStart = 0, avs_read = 0, avs_write = 0, s;
    logic [31:0] word = 0, ent = 0, nxt = 0, iv = 0, avs_writedata = 0, q, interpResult;
    logic [31:0] avs_readdata;
    logic [3:0] avs_address = 0;
    logic insnValid, ctrlValid, interpDone, avs_waitrequest;
    logic [15:0] opword, extWord;
    logic [7:0] interpOffset;
    ohd_ctrl_s ctrl;
    int err_count = 0, checks_done = 0, k;
    ohd_fetch_model u_ohd_fetch_model (.ref_clk(ref_clk), .reset_n(reset_n), .go(go),
        .word(word), .insnValid(insnValid), .opword(opword), .extWord(extWord));
    ohd_decoder u_ohd_decoder (.ref_clk(ref_clk), .reset_n(reset_n), .insnValid(insnValid),
        .opword(opword), .extWord(extWord), .ctrlValid(ctrlValid), .ctrl(ctrl),
        .interpStart(interpStart), .interpEntry(ent), .interpNext(nxt),
        .independentVar(iv), .interpDone(interpDone), .interpResult(interpResult),
        .interpOffset(interpOffset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task conclude;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task dec(input logic [31:0] w);
        int n;
        @(posedge ref_clk);
        go <= 1'b1;
        word <= w;
        @(posedge ref_clk);
        go <= 1'b0;
        s = 1'b0;
        for (n = 0; n < 4 && !s; n++) begin
            @(negedge ref_clk);
            s = (ctrlValid === 1'b1);
        end
    endtask : dec
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        chk(avs_waitrequest, 0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task ip(input logic [31:0] e, input logic [31:0] x, input logic [31:0] v,
        input logic [31:0] r);
        @(posedge ref_clk);
        interpStart <= 1'b1;
        ent <= e;
        nxt <= x;
        iv <= v;
        @(posedge ref_clk);
        interpStart <= 1'b0;
        @(negedge ref_clk);
        chk(interpDone, 1);
        chk(interpResult, r);
    endtask : ip
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        bus(0, OHD_OFS_CTRL, 0);
        chk(q[0], OHD_RST_ENABLE);
        for (k = 0; k < 3; k++) begin
            dec(32'hB110 + (k << 6));
            chk({s, ctrl.op, ctrl.dstIsEa, ctrl.size}, {1'b1, OHD_OP_XOR_EA, 1'b1, 2'(k)});
            dec(32'hB108 + (k << 6));
            chk({ctrl.op, ctrl.size}, {OHD_OP_COMPARE_MEMORY_POSTINC, 2'(k)});
        end
        for (k = 0; k < 2; k++) begin
            dec(32'hC0C0 + (k << 8));
            chk({ctrl.op, ctrl.isSigned}, {OHD_OP_MUL, 1'(k)});
            dec(32'hC100 + (k << 3));
            chk({ctrl.op, ctrl.memToMem, ctrl.predec}, {OHD_OP_BCD_ADD, 2'(k * 3)});
            dec(32'hD140 + (k << 3));
            chk({ctrl.op, ctrl.memToMem, ctrl.predec}, {OHD_OP_ADD_WITH_EXTEND, 2'(k * 3)});
            dec(32'hD0C0 + (k << 8));
            chk({ctrl.op, ctrl.size}, {OHD_OP_ADD_TO_ADDRESS_REG, k ? OHD_SZ_L : OHD_SZ_W});
        end
        for (k = 0; k < 16; k++) begin
            dec(32'hE040 | ((k ^ 5) & 7) << 9 | k[1] << 8 | k[0] << 5 | k[3:2] << 3);
            chk({ctrl.op, ctrl.cntIsReg, ctrl.cntField, ctrl.dirLeft, ctrl.shType},
                {OHD_OP_SHIFT_REG, k[0], 3'((k ^ 5) & 7), k[1], k[3:2]});
        end
        dec(32'hE8C0);
        chk({ctrl.illegal, ctrl.op}, {1'b1, OHD_OP_OTHER});
        bus(0, OHD_OFS_STATUS, 0);
        chk(q[15:0], 1);
        dec(32'h1041_F800);
        chk({ctrl.op, ctrl.isSigned, ctrl.rounded, ctrl.size, ctrl.tblRegPair},
            {OHD_OP_TBL, 2'b11, OHD_SZ_W, 1'b1});
        ip(1311, 1966, 32'h028E, 1674);
        chk(interpOffset, 2);
        ip(1, 2, 32'h0080, 2);
        ip(2, 3, 32'h0080, 2);
        ip(0, 32'hFFFE, 32'h0080, 32'hFFFF_FFFF);
        dec(32'h1841_F800);
        chk(ctrl.isSigned, 0);
        ip(0, 32'hFFFE, 32'h0080, 32'h0000_7FFF);
        dec(32'h1441_F800);
        chk(ctrl.rounded, 0);
        ip(1311, 1966, 32'h028E, 1311 * 256 + 142 * 655);
        dec(32'h1140_F810);
        chk({ctrl.op, ctrl.tblRegPair}, {OHD_OP_TBL, 1'b0});
        dec(32'h10C1_F800);
        chk(ctrl.illegal, 1);
        dec(32'h1001_F800);
        chk(ctrl.size, OHD_SZ_B);
        ip(5, 9, 32'h0300, 5);
        chk(interpOffset, 3);
        ip(0, 1, 32'h0080, 0);
        ip(32'hF0, 32'hF2, 32'h0080, 32'hFFFF_FFF1);
        dec(32'h1C01_F800);
        ip(32'h1234_56AB, 0, 32'h0100, 32'h0000_AB00);
        dec(32'hE5D0);
        chk({ctrl.op, ctrl.shType, ctrl.dirLeft}, {OHD_OP_SHIFT_MEM, 2'h2, 1'b1});
        dec(32'hC250);
        chk({ctrl.op, ctrl.size, ctrl.dstIsEa}, {OHD_OP_AND, OHD_SZ_W, 1'b0});
        dec(32'hD390);
        chk({ctrl.op, ctrl.size, ctrl.dstIsEa}, {OHD_OP_ADD, OHD_SZ_L, 1'b1});
        dec(32'hC38A);
        chk({ctrl.op, ctrl.swapMode, ctrl.regX, ctrl.regY}, {OHD_OP_SWAP, 2'b11, 3'h1, 3'h2});
        dec(32'h01C0_F800);
        chk(ctrl.op, OHD_OP_HALT);
        bus(0, OHD_OFS_LAST, 0);
        chk(q, 32'h01C0_F800);
        bus(1, OHD_OFS_CTRL, 0);
        dec(32'hC0C0);
        chk(s, 0);
        bus(0, 4'hC, 0);
        chk(q, 0);
        bus(1, OHD_OFS_CTRL, 1);
        dec(32'hC0C0);
        chk(s, 1);
        conclude();
    end
endmodule : opcode_decode_hi_lines_table_interp_test
